// >>> rtl/valve_stepper_defs.vh
// Constants for the expansion valve stepper phase sequencer
// Contract
// - Four states: 1=A+D, 2=A+B, 3=B+C, 4=C+D; other phases off.
// - Close steps 1,2,3,4,1; open steps 4,3,2,1,4.
// - All phase outputs off whenever no opening change is commanded; the code holds the last step's pattern one interval before switching off.
// - At power-on issue 2200 closing steps, then call that position zero.
// - Opening is set by net step count, linear per step.
// - Pulses sequence across four coils; direction only by traversal order.
// - Never skip a state nor energize a phase outside its state.
`ifndef VALVE_STEPPER_DEFS_VH
`define VALVE_STEPPER_DEFS_VH
`define CLK_PERIOD_NS 5
`define STEP_INTERVAL_US 2000
`define STEP_INTERVAL_CYC ((`STEP_INTERVAL_US * 1000) / `CLK_PERIOD_NS)
`define HOME_STEPS 12'h0898
`define POS_WIDTH 12
`define PHASE_S1 4'h9
`define PHASE_S2 4'h3
`define PHASE_S3 4'h6
`define PHASE_S4 4'hC
`define PHASE_OFF 4'h0
`define IDX_HOME_START 2'h3
`define POS_ORIGIN 12'h000
`endif

// >>> rtl/step_tick_gen.v
// Step rate divider producing a one-cycle enable pulse
`timescale 1ns/100ps
module step_tick_gen #(
   parameter [31:0] INTERVAL = 32'h0006_1a80
) (
   input wire core_clk, // System clock
   input wire rstn, // Synchronous reset, active low
   input wire run, // Counting allowed; held at zero otherwise
   output reg tick // One-cycle step enable
);
   reg [31:0] cnt_reg;
   always @(posedge core_clk) begin
      if (!rstn || !run) begin
         cnt_reg <= 32'h0000_0000;
         tick <= 1'b0;
      end else if (cnt_reg >= INTERVAL - 32'h0000_0001) begin
         cnt_reg <= 32'h0000_0000;
         tick <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 32'h0000_0001;
         tick <= 1'b0;
      end
   end
endmodule

// >>> rtl/valve_stepper_phase_sequencer.v
// Four-phase stepper sequencer for the electronic expansion valve
`timescale 1ns/100ps
`include "valve_stepper_defs.vh"
module valve_stepper_phase_sequencer #(
   parameter [31:0] STEP_INTERVAL = `STEP_INTERVAL_CYC,
   parameter [11:0] HOME_STEPS = `HOME_STEPS
) (
   input wire core_clk, // System clock, 200 MHz
   input wire rstn, // Synchronous reset, active low
   input wire [11:0] target_pos, // Commanded opening in steps from closed
   output reg [3:0] expansion_valve_motor, // Coil phases A..D in bits 0..3
   output reg [11:0] position, // Current opening in steps
   output reg homing, // Power-on close run in progress
   output reg moving // A step run is active
);
   localparam [2:0] ST_HOME = 3'b001;
   localparam [2:0] ST_IDLE = 3'b010;
   localparam [2:0] ST_MOVE = 3'b100;

   // Coil pattern of an excitation state; index 0..3 stands for states 1..4
   function [3:0] phase_of;
      input [1:0] idx;
      begin
         case (idx)
            2'h0: phase_of = `PHASE_S1;
            2'h1: phase_of = `PHASE_S2;
            2'h2: phase_of = `PHASE_S3;
            default: phase_of = `PHASE_S4;
         endcase
      end
   endfunction

   // One state on in the closing order, 4 wraps to 1
   function [1:0] idx_close;
      input [1:0] idx;
      begin
         idx_close = idx + 2'h1;
      end
   endfunction

   // One state on in the opening order, 1 wraps to 4
   function [1:0] idx_open;
      input [1:0] idx;
      begin
         idx_open = idx - 2'h1;
      end
   endfunction

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [1:0] idx_reg;
   reg [1:0] idx_next;
   reg [11:0] home_cnt_reg;
   reg [11:0] home_cnt_next;
   reg [11:0] pos_reg;
   reg [11:0] pos_next;
   reg energized_reg;
   reg energized_next;
   reg [3:0] motor_next;
   wire tick;
   wire run;
   wire want_close;
   wire want_open;
   wire home_done;
   wire step_home;
   wire step_close;
   wire step_open;

   assign want_close = (target_pos < pos_reg);
   assign want_open = (target_pos > pos_reg);
   assign home_done = (home_cnt_reg == HOME_STEPS);
   assign run = (state_reg != ST_IDLE);
   // A step is issued only on a divider tick
   assign step_home = (state_reg == ST_HOME) && tick && !home_done;
   assign step_close = (state_reg == ST_MOVE) && tick && want_close;
   assign step_open = (state_reg == ST_MOVE) && tick && want_open;

   // Divider restarts with each run, so a full interval precedes the first step
   step_tick_gen #(.INTERVAL(STEP_INTERVAL)) u_tick (
      .core_clk(core_clk),
      .rstn(rstn),
      .run(run),
      .tick(tick)
   );

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_HOME: begin
            // Leave only after the last homing step has stood a full interval
            if (tick && home_done) begin
               state_next = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (want_close || want_open) begin
               state_next = ST_MOVE;
            end
         end
         ST_MOVE: begin
            // The final step keeps its pattern for a full interval, else the rotor misses it
            if (tick && !want_close && !want_open) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_HOME;
         end
      endcase
   end

   always @* begin
      idx_next = idx_reg;
      if (step_home || step_close) begin
         idx_next = idx_close(idx_reg);
      end else if (step_open) begin
         idx_next = idx_open(idx_reg);
      end
   end

   always @* begin
      home_cnt_next = home_cnt_reg;
      if (step_home) begin
         home_cnt_next = home_cnt_reg + 12'h001;
      end
   end

   always @* begin
      pos_next = pos_reg;
      if (state_reg == ST_HOME) begin
         pos_next = `POS_ORIGIN;
      end else if (step_close) begin
         if (pos_reg != 12'h000) begin
            pos_next = pos_reg - 12'h001;
         end
      end else if (step_open) begin
         pos_next = pos_reg + 12'h001;
      end
   end

   always @* begin
      energized_next = energized_reg;
      if (state_next == ST_IDLE) begin
         energized_next = 1'b0;
      end else if (step_home || step_close || step_open) begin
         energized_next = 1'b1;
      end
   end

   always @* begin
      motor_next = `PHASE_OFF;
      if (energized_next) begin
         motor_next = phase_of(idx_next);
      end
   end

   always @(posedge core_clk) begin
      if (!rstn) begin
         state_reg <= ST_HOME;
      end else begin
         state_reg <= state_next;
      end
   end

   always @(posedge core_clk) begin
      if (!rstn) begin
         idx_reg <= `IDX_HOME_START;
      end else begin
         idx_reg <= idx_next;
      end
   end

   always @(posedge core_clk) begin
      if (!rstn) begin
         home_cnt_reg <= 12'h000;
      end else begin
         home_cnt_reg <= home_cnt_next;
      end
   end

   always @(posedge core_clk) begin
      if (!rstn) begin
         pos_reg <= `POS_ORIGIN;
      end else begin
         pos_reg <= pos_next;
      end
   end

   always @(posedge core_clk) begin
      if (!rstn) begin
         energized_reg <= 1'b0;
      end else begin
         energized_reg <= energized_next;
      end
   end

   // Outputs load the next values so that pins and internal state agree
   always @(posedge core_clk) begin
      if (!rstn) begin
         expansion_valve_motor <= `PHASE_OFF;
      end else begin
         expansion_valve_motor <= motor_next;
      end
   end

   always @(posedge core_clk) begin
      if (!rstn) begin
         position <= `POS_ORIGIN;
      end else begin
         position <= pos_next;
      end
   end

   always @(posedge core_clk) begin
      if (!rstn) begin
         homing <= 1'b1;
      end else begin
         homing <= (state_next == ST_HOME);
      end
   end

   always @(posedge core_clk) begin
      if (!rstn) begin
         moving <= 1'b0;
      end else begin
         moving <= (state_next == ST_MOVE);
      end
   end
endmodule

// >>> verif/valve_stepper_properties.sv
// Checker for the valve stepper sequencer
`timescale 1ns/100ps
module valve_stepper_checker #(
   parameter [31:0] STEP_INTERVAL = 32'h0006_1a80
) (
   input wire core_clk, // Clock
   input wire rstn, // Reset, active low
   input wire [11:0] target_pos, // Target
   input wire [3:0] expansion_valve_motor, // Phases
   input wire [11:0] position, // Position
   input wire homing, // Close run
   input wire moving // Move active
);
   reg [3:0] mp;
   wire [3:0] m = expansion_valve_motor;
   always @(posedge core_clk) mp <= m;
   reg [31:0] stop_cnt;
   // Cycles spent moving with the target already reached
   always @(posedge core_clk)
      if (!rstn || homing || !moving || position != target_pos) stop_cnt <= 32'h0;
      else stop_cnt <= stop_cnt + 32'h1;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   a_legal_pattern: assert property (m inside {4'h0, 4'h9, 4'h3, 4'h6, 4'hC})
      else $error("bad pattern");
   a_no_skip: assert property (m != mp && m != 0 && mp != 0 |->
      m == {mp[2:0], mp[3]} || m == {mp[0], mp[3:1]}) else $error("skipped state");
   a_home_close: assert property (homing && m != mp && m != 0 && mp != 0 |->
      m == {mp[2:0], mp[3]}) else $error("homing not closing");
   a_idle_off: assert property ((!homing && !moving)[*4] |-> m == 0)
      else $error("phase on while idle");
   a_pos_step: assert property ($changed(position) |-> position == $past(position) + 1
      || position == $past(position) - 1) else $error("position jump");
   a_home_zero: assert property (homing |-> position == 12'h000)
      else $error("position moved in homing");
   a_home_still: assert property (homing |-> !moving) else $error("move in homing");
   a_reach_stop: assert property (stop_cnt <= STEP_INTERVAL + 32'h1)
      else $error("move past target");
   c_home_end: cover property ($fell(homing));
   c_open: cover property (position > $past(position));
   c_close: cover property (!homing && position < $past(position));
endmodule
bind valve_stepper_phase_sequencer valve_stepper_checker #(.STEP_INTERVAL(STEP_INTERVAL))
   chk (.core_clk(core_clk), .rstn(rstn),
   .target_pos(target_pos), .expansion_valve_motor(expansion_valve_motor),
   .position(position), .homing(homing), .moving(moving));

// >>> verif/coil_model.sv
// Valve coil model: tracks steps and opening, flags bad sequences
`timescale 1ns/100ps
module coil_model (
   input wire core_clk, // Clock
   input wire [3:0] phases, // Coil drive
   output reg [31:0] opened, // Opening in steps
   output reg [31:0] steps, // Steps seen
   output reg bad // Bad sequence seen
);
   reg [3:0] last = 4'h0;
   initial {opened, steps, bad} = 0;
   // Rotor rests in its last state while coils are off
   always @(posedge core_clk) if (phases != last && phases != 0) begin
      steps <= steps + 1;
      if (!(phases inside {4'h9, 4'h3, 4'h6, 4'hC})) bad <= 1;
      if (last != 0 && phases == {last[0], last[3:1]}) opened <= opened + 1;
      else if (last != 0 && phases == {last[2:0], last[3]}) opened <= opened - (opened != 0);
      else if (last != 0) bad <= 1;
      last <= phases;
   end
endmodule

// >>> verif/testbench.sv
// Bench for the valve stepper sequencer
`timescale 1ns/100ps
module testbench;
   reg core_clk = 0;
   reg rstn = 0;
   reg [11:0] target_pos = 12'h000;
   wire [3:0] mot;
   wire [11:0] position;
   wire homing, moving, bad;
   wire [31:0] opened, steps;
   integer n_fail = 0, checks = 0;
   valve_stepper_phase_sequencer #(.STEP_INTERVAL(32'h0000_0004), .HOME_STEPS(12'h008)) DUT (
      .core_clk(core_clk), .rstn(rstn), .target_pos(target_pos), .expansion_valve_motor(mot),
      .position(position), .homing(homing), .moving(moving));
   coil_model coils (.core_clk(core_clk), .phases(mot), .opened(opened), .steps(steps), .bad(bad));
   initial forever #2.5 core_clk = ~core_clk;
   task check(input [31:0] seen, input [31:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected %0t: got %0h want %0h", $time, seen, exp);
         end
      end
   endtask
   task final_report;
      begin
         $display("checks %0d n_fail %0d", checks, n_fail);
         if (n_fail == 0 && checks > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   task timed_out;
      begin
         n_fail = n_fail + 1;
         $display("unexpected %0t: wait limit reached", $time);
         final_report;
      end
   endtask
   task settle;
      integer i;
      begin
         for (i = 0; i < 400 &&
               (homing !== 0 || moving !== 0 || position !== target_pos); i++) begin
            @(posedge core_clk);
            #1;
         end
         if (i == 400) timed_out;
         repeat (4) @(posedge core_clk);
         #1;
      end
   endtask
   task wait_step;
      integer i;
      begin
         for (i = 0; i < 400 && mot === 4'h0; i++) begin
            @(posedge core_clk);
            #1;
         end
         if (i == 400) timed_out;
      end
   endtask
   task t_home;
      begin
         wait_step;
         check(mot, 4'h9);
         check(homing, 1);
         check(position, 0);
         settle;
         check(steps, 8);
         check(position, 0);
         check(homing, 0);
         check(mot, 0);
      end
   endtask
   task t_move(input [11:0] t, input [31:0] total, input [3:0] first);
      begin
         target_pos = t;
         wait_step;
         check(moving, 1);
         check(mot, first);
         settle;
         check(position, t);
         check(opened, t);
         check(steps, total);
         check(bad, 0);
         check(moving, 0);
         check(mot, 0);
      end
   endtask
   initial begin
      repeat (2) @(posedge core_clk);
      #1 rstn = 1;
      t_home;
      t_move(12'h005, 13, 4'h6);
      t_move(12'h000, 18, 4'hC);
      final_report;
   end
endmodule
